// ---- hdl/tmsel_top.sv ----
// test mode selector, nonmaskable and gpio seven interrupt pin logic
//
// Contract
// [RULE1] decode selector: 00 boundary scan, 11 emulation default, mixed reserved
// [RULE2] functional operation stays enabled in both scan and emulation modes; here scan mode drops it while test reset is high
// [RULE3] outside party leaves test reset at its pulled-down level in scan
// [RULE4] outside party drives selector low and device reset low for scan
// [RULE5] every rising edge on the nonmaskable input raises an interrupt pulse
// [RULE6] gpio line seven works as general io and as external irq source
// [RULE7] four polarity bits pick the trigger edge of each external irq pin
// [RULE8] selector sampled during reset, mode held fixed until next reset
`timescale 1ns/1ps
`default_nettype none
`include "tmsel_map.svh"
module tmsel_top (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_emulation_mode_select,
  input wire logic i_trst,
  input wire logic i_nmi,
  input wire logic i_gpio_line_seven,
  input wire logic i_gpio_seven_out,
  input wire logic i_gpio_seven_dir_out,
  input wire logic [3:0] i_ext_irq_polarity_bits,
  output logic o_gpio_line_seven,
  output logic o_gpio_line_seven_oe_n,
  output logic o_gpio_seven_in,
  output logic o_mode_bscan,
  output logic o_mode_emul,
  output logic o_mode_reserved,
  output logic o_functional,
  output logic o_nmi_irq,
  output logic o_external_irq_seven
);
  // ****************************************************
  // mode capture
  // ****************************************************
  tmsel_pkg::tmsel_mode_type mode_ff;
  logic [1:0] sel_s1_ff;
  logic [1:0] sel_s2_ff;
  logic [1:0] sel_s3_ff;
  logic [1:0] sel_ok_ff;
  logic held_ff;
  logic [1:0] rst_seen_ff;
  logic trst_level;

  // reserved selector codes stop functional operation
  function automatic logic mode_is_rsvd(
    input tmsel_pkg::tmsel_mode_type m
  );
    return (m == tmsel_pkg::tmsel_rsvd_a) ||
           (m == tmsel_pkg::tmsel_rsvd_b);
  endfunction

  // selector pins pass three flops while the device sits in reset
  always_ff @(posedge i_clk) begin
    sel_s1_ff <= i_emulation_mode_select;
    sel_s2_ff <= sel_s1_ff;
    sel_s3_ff <= sel_s2_ff;
  end

  // a selector change counts once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (sel_s2_ff == sel_s3_ff) begin
      sel_ok_ff <= sel_s3_ff;
    end
  end

  // test reset pin is asynchronous, so it is filtered like the irq pins
  tmsel_edge u_trst (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_pin(i_trst),
    .i_rise(1'b1),
    .o_level(trst_level),
    .o_pulse()
  );

  // held_ff drops under reset; the third clock after release latches the mode
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_seen_ff <= 2'h0;
    end else if (rst_seen_ff != 2'h3) begin
      rst_seen_ff <= rst_seen_ff + 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_ff <= tmsel_pkg::tmsel_mode_type'(`TMSEL_EMU_RST);
      held_ff <= 1'b0;
    end else if (!held_ff && rst_seen_ff == 2'h2) begin
      mode_ff <= tmsel_pkg::tmsel_mode_type'(sel_ok_ff); // RULE8
      held_ff <= 1'b1; // RULE8
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mode_bscan <= 1'b0;
      o_mode_emul <= 1'b1;
      o_mode_reserved <= 1'b0;
      o_functional <= 1'b1;
    end else begin
      o_mode_bscan <= (mode_ff == tmsel_pkg::tmsel_bscan_func); // RULE1
      o_mode_emul <= (mode_ff == tmsel_pkg::tmsel_emul_func); // RULE1
      o_mode_reserved <= mode_is_rsvd(mode_ff); // RULE1
      // functional in scan only while test reset is left low
      o_functional <= (mode_ff == tmsel_pkg::tmsel_emul_func) ||
                      ((mode_ff == tmsel_pkg::tmsel_bscan_func) &&
                       !trst_level); // RULE2 RULE3
    end
  end

  // ****************************************************
  // interrupt pins
  // ****************************************************
  logic nmi_pulse;
  logic gp7_level;
  logic gp7_pulse;

  tmsel_edge u_nmi (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_pin(i_nmi),
    .i_rise(1'b1),
    .o_level(),
    .o_pulse(nmi_pulse)
  );

  tmsel_edge u_gp7 (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_pin(i_gpio_line_seven),
    .i_rise(!i_ext_irq_polarity_bits[`TMSEL_POL_GP7]),
    .o_level(gp7_level),
    .o_pulse(gp7_pulse)
  );

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_nmi_irq <= 1'b0;
      o_external_irq_seven <= 1'b0;
    end else begin
      o_nmi_irq <= nmi_pulse; // RULE5
      o_external_irq_seven <= gp7_pulse; // RULE6 RULE7
    end
  end

  // ****************************************************
  // gpio seven pin driver
  // ****************************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_gpio_line_seven <= 1'b0;
      o_gpio_line_seven_oe_n <= 1'b1;
      o_gpio_seven_in <= 1'b0;
    end else begin
      o_gpio_line_seven <= i_gpio_seven_out; // RULE6
      o_gpio_line_seven_oe_n <= !i_gpio_seven_dir_out; // RULE6
      o_gpio_seven_in <= gp7_level; // RULE6
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  chk_mode_onehot: assert property ( // RULE1
    @(posedge i_clk) disable iff (!i_rstn)
    $onehot({o_mode_bscan, o_mode_emul, o_mode_reserved}))
    else $error("mode outputs not one-hot");

  chk_rsvd_nofunc: assert property ( // RULE1
    @(posedge i_clk) disable iff (!i_rstn)
    mode_is_rsvd(mode_ff) |=> !o_functional)
    else $error("reserved mode allowed functional operation");

  chk_mode_held: assert property ( // RULE8
    @(posedge i_clk) disable iff (!i_rstn)
    held_ff |=> $stable(mode_ff))
    else $error("mode changed after capture");

  chk_mode_latch: assert property ( // RULE8
    @(posedge i_clk) disable iff (!i_rstn)
    (!held_ff && rst_seen_ff == 2'h2) |=> (mode_ff == $past(sel_ok_ff)))
    else $error("mode not captured from selector");

  chk_emul_func: assert property ( // RULE2
    @(posedge i_clk) disable iff (!i_rstn)
    (mode_ff == tmsel_pkg::tmsel_emul_func) |=> o_functional)
    else $error("emulation mode lost functional operation");

  chk_bscan_func: assert property ( // RULE2
    @(posedge i_clk) disable iff (!i_rstn)
    ((mode_ff == tmsel_pkg::tmsel_bscan_func) && !trst_level) |=>
    o_functional)
    else $error("scan mode lost functional operation");

  chk_nmi_pulse: assert property ( // RULE5
    @(posedge i_clk) disable iff (!i_rstn)
    nmi_pulse |=> o_nmi_irq ##1 !o_nmi_irq)
    else $error("nmi pulse not one cycle");

  chk_gp7_edge: assert property ( // RULE7
    @(posedge i_clk) disable iff (!i_rstn)
    (gp7_pulse && $stable(i_ext_irq_polarity_bits)) |->
    (gp7_level == !i_ext_irq_polarity_bits[`TMSEL_POL_GP7]))
    else $error("gpio seven irq on wrong edge");

  chk_gp7_oe: assert property ( // RULE6
    @(posedge i_clk) disable iff (!i_rstn)
    i_gpio_seven_dir_out |=> !o_gpio_line_seven_oe_n)
    else $error("gpio seven not driven");

  chk_gp7_data: assert property ( // RULE6
    @(posedge i_clk) disable iff (!i_rstn)
    i_rstn |=> (o_gpio_line_seven == $past(i_gpio_seven_out)))
    else $error("gpio seven output value lost");

  chk_gp7_irq: assert property ( // RULE6
    @(posedge i_clk) disable iff (!i_rstn)
    o_external_irq_seven |-> $past(gp7_pulse))
    else $error("gpio seven irq without edge");
endmodule
`default_nettype wire

// ---- hdl/tmsel_map.svh ----
// constants for the test mode select and interrupt pin block
`ifndef TMSEL_MAP_SVH
`define TMSEL_MAP_SVH
`define TMSEL_EMU_BSCAN 2'h0
`define TMSEL_EMU_EMUL 2'h3
`define TMSEL_EMU_RST 2'h3
`define TMSEL_POL_W 4
`define TMSEL_POL_GP7 2'h3
`define TMSEL_SYNC_W 3
`endif

// ---- hdl/tmsel_pkg.sv ----
// types for the test mode select and interrupt pin block
package tmsel_pkg;
  typedef enum logic [1:0] {
    tmsel_bscan_func = 2'h0,
    tmsel_rsvd_a = 2'h1,
    tmsel_emul_func = 2'h3,
    tmsel_rsvd_b = 2'h2
  } tmsel_mode_type;
endpackage

// ---- hdl/tmsel_edge.sv ----
// three-stage pin synchroniser with selectable edge pulse
`timescale 1ns/1ps
`default_nettype none
module tmsel_edge (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_pin,
  input wire logic i_rise,
  output logic o_level,
  output logic o_pulse
);
  logic [2:0] sync_ff;
  logic level_ff;
  logic pulse_ff;
  logic agree;
  logic nxt_level;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_ff <= 3'h0;
    end else begin
      sync_ff <= {sync_ff[1:0], i_pin};
    end
  end

  // a change counts once stages two and three agree
  assign agree = (sync_ff[1] == sync_ff[2]);
  assign nxt_level = agree ? sync_ff[2] : level_ff;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      level_ff <= 1'b0;
      pulse_ff <= 1'b0;
    end else begin
      level_ff <= nxt_level;
      pulse_ff <= (nxt_level != level_ff) && (nxt_level == i_rise);
    end
  end

  assign o_level = level_ff;
  assign o_pulse = pulse_ff;
endmodule
`default_nettype wire

// ---- test/tmsel_board.sv ----
// board side model: selector pins, test reset and the gpio seven wire
`timescale 1ns/1ps
`default_nettype none
module tmsel_board (
  input wire logic [1:0] i_sel,
  input wire logic i_val,
  input wire logic i_dev_val,
  input wire logic i_dev_oe_n,
  input wire logic i_trst_drv,
  output logic [1:0] o_sel,
  output logic o_trst,
  output logic o_pin
);
  // selector is set while the bench holds device reset low, and the bench changes it again after release
  assign o_sel = i_sel;
  // test reset stays pulled down unless the bench opposes it on purpose
  assign o_trst = i_trst_drv;
  assign o_pin = i_dev_oe_n ? i_val : i_dev_val;
endmodule
`default_nettype wire

// ---- test/tmsel_top_tb.sv ----
// self-checking bench for the test mode select and interrupt pin block
`timescale 1ns/1ps
`default_nettype none
module tmsel_top_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic nmi = 1'b0;
  logic val = 1'b0;
  logic gdir = 1'b0;
  logic tdrv = 1'b0;
  logic [1:0] sel = 2'h3;
  logic [3:0] pol = 4'h0;
  logic [31:0] seed = 32'hebe2;
  logic [1:0] emu;
  logic trst, pin, gp_o, oe_n, gp_in, bs, em, rs, fn, nirq, eirq;
  int bad_count = 0;
  int check_count = 0;
  logic nq[$];
  logic eq[$];
  initial forever #2.5 clk = ~clk;
  tmsel_board tmsel_board_i (.i_sel(sel), .i_val(val), .i_dev_val(gp_o),
    .i_dev_oe_n(oe_n), .i_trst_drv(tdrv), .o_sel(emu), .o_trst(trst),
    .o_pin(pin));
  tmsel_top tmsel_top_i (.i_clk(clk), .i_rstn(rstn),
    .i_emulation_mode_select(emu), .i_trst(trst), .i_nmi(nmi),
    .i_gpio_line_seven(pin), .i_gpio_seven_out(val),
    .i_gpio_seven_dir_out(gdir), .i_ext_irq_polarity_bits(pol),
    .o_gpio_line_seven(gp_o), .o_gpio_line_seven_oe_n(oe_n),
    .o_gpio_seven_in(gp_in), .o_mode_bscan(bs), .o_mode_emul(em),
    .o_mode_reserved(rs), .o_functional(fn), .o_nmi_irq(nirq),
    .o_external_irq_seven(eirq));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] code, input logic p);
    @(posedge clk);
    #1 rstn = 1'b0;
    sel = code;
    pol = {p, 3'h0};
    val = p;
    gdir = 1'b0;
    nmi = 1'b0;
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask
  // each pulse must match a pending note
  always @(negedge clk) begin
    if (nirq !== 1'b0) begin
      check("nmi_irq", nq.size() > 0, nirq);
      if (nq.size() > 0) void'(nq.pop_front());
    end
    if (eirq !== 1'b0) begin
      check("ext_irq", eq.size() > 0, eirq);
      if (eq.size() > 0) void'(eq.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    int k;
    logic [31:0] r;
    logic prev;
    for (k = 0; k < 4; k++) begin
      do_reset(k[1:0], 1'b0);
      check("bscan", k == 0, bs);
      check("emul", k == 3, em);
      check("rsvd", k == 1 || k == 2, rs);
      check("func", k == 0 || k == 3, fn);
      sel = ~sel;
      tdrv = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      check("held", k == 3, em);
      check("func_trst", k == 3, fn);
      tdrv = 1'b0;
    end
    for (k = 0; k < 2; k++) begin
      do_reset(2'h3, k[0]);
      prev = k[0];
      repeat (40) begin
        r = xs();
        gdir = r[1];
        val = r[0];
        if (r[0] != prev && r[0] != k[0]) eq.push_back(1'b1);
        prev = r[0];
        if (r[2] && !nmi) nq.push_back(1'b1);
        nmi = r[2];
        repeat (6) @(posedge clk);
        #1;
        check("oe_n", ~gdir, oe_n);
        if (gdir) check("pin_out", val, gp_o);
        check("pin_in", prev, gp_in);
      end
      repeat (8) @(posedge clk);
      check("left", 1'b1, nq.size() + eq.size() == 0);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
